/* File: hdl/lin_regs.svh */
`ifndef LIN_REGS_SVH
`define LIN_REGS_SVH

// clock and bit rate
`define LIN_CLK_HZ        20000000
`define LIN_BIT_RATE      19200
`define LIN_OVS           16

// sampling window inside one bit, in sixteenths
`define LIN_SYNC_ACC      2
`define LIN_SAMPLE_FIRST  7
`define LIN_SAMPLE_LAST   9
`define LIN_BIT_LAST      15

// dominant pulse limits, in bit times
`define LIN_BREAK_BITS    11
`define LIN_HDR_MAX_BITS  48

// link error flag positions and reset value
`define LIN_ERR_BIT       0
`define LIN_ERR_HEADER    1
`define LIN_ERR_DATA      2
`define LIN_ERR_TIMEOUT   3
`define LIN_ERR_RESP      4
`define LIN_ERR_RESET     8'h00

// field values
`define LIN_SYNC_BYTE     8'h55
`define LIN_PID_DIAG_REQ  6'h3C
`define LIN_PID_DIAG_RSP  6'h3D
`define LIN_NAD_MIN       7'h01
`define LIN_NAD_MAX       7'h7D
`define LIN_NAD_BCAST     8'h7F

`endif

/* File: hdl/lin_pkg.sv */
package lin_pkg;

  typedef enum logic [1:0] {FR_IDLE, FR_SYNC, FR_PID, FR_DATA} frame_state_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

/* File: hdl/lin_byte_rx.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lin_regs.svh"

module lin_byte_rx (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       rxd,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_data,
  output var  logic       stop_ok
);

  lin_pkg::rx_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [2:0] bitn_ff, nxt_bitn;
  logic [1:0] votes_ff, nxt_votes;
  logic       prev_ff, nxt_prev;
  logic [7:0] sh_ff, nxt_sh;
  logic       valid_ff, nxt_valid;
  logic       stop_ff, nxt_stop;
  logic       in_win;
  logic       maj;
  logic [1:0] total;

  // sample window and vote over three samples
  always_comb begin
    in_win = (cnt_ff >= 4'(`LIN_SAMPLE_FIRST)) && (cnt_ff <= 4'(`LIN_SAMPLE_LAST));
    total  = votes_ff + {1'b0, rxd};
    maj    = (total >= 2'd2);
  end

  // bit timing restarted at every start edge
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_bitn  = bitn_ff;
    nxt_votes = votes_ff;
    nxt_prev  = prev_ff;
    nxt_sh    = sh_ff;
    nxt_valid = 1'b0;
    nxt_stop  = stop_ff;
    if (tick) begin
      nxt_prev = rxd;
      if (state_ff == lin_pkg::RX_IDLE) begin
        if (prev_ff && !rxd) begin
          nxt_state = lin_pkg::RX_START;
          nxt_cnt   = 4'h1; // edge tick is the first sixteenth, keeps last sample at 9/16
          nxt_bitn  = 3'h0;
          nxt_votes = 2'h0;
        end
      end else begin
        nxt_cnt = cnt_ff + 4'h1;
        if (in_win && cnt_ff != 4'(`LIN_SAMPLE_LAST)) begin
          nxt_votes = total;
        end
        if (cnt_ff == 4'(`LIN_SAMPLE_LAST)) begin
          case (state_ff)
            lin_pkg::RX_START: begin
              if (maj) begin
                nxt_state = lin_pkg::RX_IDLE; // glitch, not a start bit
              end
            end
            lin_pkg::RX_DATA: begin
              nxt_sh = {maj, sh_ff[7:1]};
            end
            lin_pkg::RX_STOP: begin
              nxt_valid = 1'b1;
              nxt_stop  = maj;
              nxt_state = lin_pkg::RX_IDLE;
            end
            default: begin
              nxt_state = lin_pkg::RX_IDLE;
            end
          endcase
        end
        if (cnt_ff == 4'(`LIN_BIT_LAST)) begin
          nxt_votes = 2'h0;
          if (state_ff == lin_pkg::RX_START) begin
            nxt_state = lin_pkg::RX_DATA;
          end else if (state_ff == lin_pkg::RX_DATA) begin
            nxt_bitn = bitn_ff + 3'h1;
            if (bitn_ff == 3'h7) begin
              nxt_state = lin_pkg::RX_STOP;
            end
          end
        end
      end
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= lin_pkg::RX_IDLE;
      cnt_ff   <= 4'h0;
      bitn_ff  <= 3'h0;
      votes_ff <= 2'h0;
      prev_ff  <= 1'b1;
      sh_ff    <= 8'h00;
      valid_ff <= 1'b0;
      stop_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      bitn_ff  <= nxt_bitn;
      votes_ff <= nxt_votes;
      prev_ff  <= nxt_prev;
      sh_ff    <= nxt_sh;
      valid_ff <= nxt_valid;
      stop_ff  <= nxt_stop;
    end
  end

  assign byte_valid = valid_ff;
  assign byte_data  = sh_ff;
  assign stop_ok    = stop_ff;

  // vote result one cycle late, for the window check
  logic maj_q;
  always_ff @(posedge clk) begin
    maj_q <= maj;
  end

  // falling edge seen on a tick while idle
  sequence s_start_edge;
    tick && state_ff == lin_pkg::RX_IDLE && prev_ff && !rxd;
  endsequence

  a_resync_edge: assert property (@(posedge clk) disable iff (rst)
    s_start_edge |=> state_ff == lin_pkg::RX_START && cnt_ff == 4'h1)
    else $error("byte timing not restarted on start edge");

  a_sample_window: assert property (@(posedge clk) disable iff (rst)
    (tick && state_ff == lin_pkg::RX_DATA && cnt_ff == 4'(`LIN_SAMPLE_LAST))
      |=> sh_ff[7] == maj_q)
    else $error("data bit not taken from the window vote");

endmodule // lin_byte_rx

`default_nettype wire

/* File: hdl/lin_node_address.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lin_regs.svh"

module lin_node_address (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       latch_req,
  input  wire logic [3:0] otp_addr,
  input  wire logic       address_mode_select,
  input  wire logic [2:0] hardwired_address_pins,
  input  wire logic       top_pin_resolved,
  output var  logic [6:0] node_addr,
  output var  logic       addr_valid
);

  logic [6:0] addr_ff, nxt_addr;
  logic       valid_ff, nxt_valid;
  logic [3:0] otp_eff;

  // otp bit 0 inverted in both modes, then arranged by mode
  always_comb begin
    otp_eff   = {otp_addr[3:1], ~otp_addr[0]};
    nxt_addr  = addr_ff;
    nxt_valid = valid_ff;
    if (latch_req && !valid_ff && top_pin_resolved) begin
      nxt_valid = 1'b1;
      if (address_mode_select) begin
        nxt_addr = {hardwired_address_pins, otp_eff};
      end else begin
        nxt_addr = {otp_eff, hardwired_address_pins};
      end
    end
  end

  // held until the next reset
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_ff  <= 7'h00;
      valid_ff <= 1'b0;
    end else begin
      addr_ff  <= nxt_addr;
      valid_ff <= nxt_valid;
    end
  end

  assign node_addr  = addr_ff;
  assign addr_valid = valid_ff;

  a_addr_frozen: assert property (@(posedge clk) disable iff (rst)
    valid_ff |=> valid_ff && $stable(addr_ff))
    else $error("node address changed after latching");

  a_addr_deferred: assert property (@(posedge clk) disable iff (rst)
    (!valid_ff && !top_pin_resolved) |=> !valid_ff)
    else $error("address latched while top pin floating");

endmodule // lin_node_address

`default_nettype wire

/* File: hdl/lin_slave_protocol_handler.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lin_regs.svh"

module lin_slave_protocol_handler #(
  parameter int OVS_DIV = `LIN_CLK_HZ / (`LIN_OVS * `LIN_BIT_RATE)
) (
  // clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  // bus receiver and transmitter
  input  wire logic       LIN_RXD,
  output var  logic       LIN_TXD,
  // address sources
  input  wire logic [3:0] OTP_ADDR,
  input  wire logic       ADDRESS_MODE_SELECT,
  input  wire logic [2:0] HARDWIRED_ADDRESS_PINS,
  input  wire logic       HARDWIRED_ADDRESS_TOP_PIN_RESOLVED,
  // response bytes
  input  wire logic       TX_REQ,
  input  wire logic [7:0] TX_DATA,
  output var  logic       TX_BUSY,
  // served read commands
  input  wire logic       READ_FULL_STATUS_CMD,
  input  wire logic       READ_POSITION_CMD,
  // status
  output var  logic [7:0] LINK_ERROR_FLAGS,
  output var  logic [6:0] NODE_ADDR,
  output var  logic       NODE_ADDR_VALID,
  // received frame
  output var  logic       HEADER_VALID,
  output var  logic [7:0] PID,
  output var  logic       RX_VALID,
  output var  logic [7:0] RX_DATA,
  output var  logic       NAD_HIT,
  output var  logic       FRAME_OK
);

  localparam int          DIV_W      = $clog2(OVS_DIV + 1);
  localparam logic [9:0]  BREAK_TICK = 10'(`LIN_BREAK_BITS * `LIN_OVS);
  localparam logic [9:0]  HDR_TICK   = 10'(`LIN_HDR_MAX_BITS * `LIN_OVS);
  localparam logic [3:0]  TX_SAMPLE  = 4'(`LIN_SAMPLE_FIRST + 1);

  // inverted-later sum with end-around carry
  function automatic logic [7:0] add_carry(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  // oversampling divider
  logic [DIV_W-1:0] div_ff, nxt_div;
  logic             tick_ff, nxt_tick;

  always_comb begin
    nxt_tick = 1'b0;
    nxt_div  = div_ff + DIV_W'(1);
    if (div_ff == DIV_W'(OVS_DIV - 1)) begin
      nxt_div  = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  // byte receiver and address latch
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       rx_stop_ok;
  logic [6:0] node_addr;
  logic       addr_valid;
  logic       latch_req;

  lin_byte_rx u_rx (
    .clk        (REF_CLK),
    .rst        (RST),
    .tick       (tick_ff),
    .rxd        (LIN_RXD),
    .byte_valid (rx_valid),
    .byte_data  (rx_byte),
    .stop_ok    (rx_stop_ok)
  );

  lin_node_address u_addr (
    .clk                    (REF_CLK),
    .rst                    (RST),
    .latch_req              (latch_req),
    .otp_addr               (OTP_ADDR),
    .address_mode_select    (ADDRESS_MODE_SELECT),
    .hardwired_address_pins (HARDWIRED_ADDRESS_PINS),
    .top_pin_resolved       (HARDWIRED_ADDRESS_TOP_PIN_RESOLVED),
    .node_addr              (node_addr),
    .addr_valid             (addr_valid)
  );

  // frame state
  lin_pkg::frame_state_t fr_ff, nxt_fr;
  logic [9:0] dom_ff, nxt_dom;
  logic [7:0] pid_ff, nxt_pid;
  logic [3:0] len_ff, nxt_len;
  logic [3:0] idx_ff, nxt_idx;
  logic [7:0] sum_ff, nxt_sum;
  logic       diag_ff, nxt_diag;
  logic       hv_ff, nxt_hv;
  logic       rxv_ff, nxt_rxv;
  logic [7:0] rxd_ff, nxt_rxd;
  logic       hit_ff, nxt_hit;
  logic       ok_ff, nxt_ok;
  logic       break_ev, hdr_ev, data_ev, to_ev;
  logic       par_ok, id_diag;
  logic [5:0] id;

  // identifier parity and frame class
  always_comb begin
    id      = rx_byte[5:0];
    par_ok  = (rx_byte[6] == ^{id[0], id[1], id[2], id[4]})
           && (rx_byte[7] == ~^{id[1], id[3], id[4], id[5]});
    id_diag = (id == `LIN_PID_DIAG_REQ) || (id == `LIN_PID_DIAG_RSP);
    break_ev = tick_ff && LIN_RXD && (dom_ff >= BREAK_TICK);
    to_ev    = tick_ff && !LIN_RXD && (dom_ff == HDR_TICK);
    latch_req = (fr_ff == lin_pkg::FR_SYNC) && rx_valid && rx_stop_ok
             && (rx_byte == `LIN_SYNC_BYTE);
  end

  // header and data field tracking
  always_comb begin
    nxt_fr   = fr_ff;
    nxt_dom  = dom_ff;
    nxt_pid  = pid_ff;
    nxt_len  = len_ff;
    nxt_idx  = idx_ff;
    nxt_sum  = sum_ff;
    nxt_diag = diag_ff;
    nxt_hv   = 1'b0;
    nxt_rxv  = 1'b0;
    nxt_rxd  = rxd_ff;
    nxt_hit  = hit_ff;
    nxt_ok   = 1'b0;
    hdr_ev   = 1'b0;
    data_ev  = 1'b0;
    if (tick_ff) begin
      if (LIN_RXD) begin
        nxt_dom = 10'h000;
      end else if (dom_ff != 10'h3FF) begin
        nxt_dom = dom_ff + 10'h001;
      end
    end
    if (break_ev) begin
      data_ev = (fr_ff == lin_pkg::FR_DATA); // frame cut short
      nxt_fr  = lin_pkg::FR_SYNC;
    end else if (rx_valid) begin
      case (fr_ff)
        lin_pkg::FR_SYNC: begin
          nxt_fr = lin_pkg::FR_IDLE;
          if (!rx_stop_ok) begin
            hdr_ev = addr_valid;
          end else if (latch_req && addr_valid) begin
            nxt_fr = lin_pkg::FR_PID;
          end
        end
        lin_pkg::FR_PID: begin
          nxt_fr = lin_pkg::FR_IDLE;
          if (!rx_stop_ok || !par_ok) begin
            hdr_ev = 1'b1;
          end else begin
            nxt_fr   = lin_pkg::FR_DATA;
            nxt_pid  = rx_byte;
            nxt_hv   = 1'b1;
            nxt_diag = id_diag;
            nxt_idx  = 4'h0;
            nxt_hit  = 1'b0;
            nxt_sum  = id_diag ? 8'h00 : rx_byte;
            case (id[5:4])
              2'b10:   nxt_len = 4'd4;
              2'b11:   nxt_len = 4'd8;
              default: nxt_len = 4'd2;
            endcase
            if (id_diag) begin
              nxt_len = 4'd8;
            end
          end
        end
        lin_pkg::FR_DATA: begin
          if (!rx_stop_ok) begin
            data_ev = 1'b1;
            nxt_fr  = lin_pkg::FR_IDLE;
          end else if (idx_ff == len_ff) begin
            nxt_fr = lin_pkg::FR_IDLE;
            if (~sum_ff != rx_byte) begin
              data_ev = 1'b1;
            end else begin
              nxt_ok = 1'b1;
            end
          end else begin
            nxt_sum = add_carry(sum_ff, rx_byte);
            nxt_idx = idx_ff + 4'h1;
            nxt_rxv = 1'b1;
            nxt_rxd = rx_byte;
            if (diag_ff && idx_ff == 4'h0) begin
              nxt_hit = (rx_byte == `LIN_NAD_BCAST)
                     || (rx_byte == {1'b0, node_addr}
                         && node_addr >= `LIN_NAD_MIN && node_addr <= `LIN_NAD_MAX);
            end
          end
        end
        default: begin
          nxt_fr = lin_pkg::FR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      fr_ff   <= lin_pkg::FR_IDLE;
      dom_ff  <= 10'h000;
      pid_ff  <= 8'h00;
      len_ff  <= 4'h0;
      idx_ff  <= 4'h0;
      sum_ff  <= 8'h00;
      diag_ff <= 1'b0;
      hv_ff   <= 1'b0;
      rxv_ff  <= 1'b0;
      rxd_ff  <= 8'h00;
      hit_ff  <= 1'b0;
      ok_ff   <= 1'b0;
    end else begin
      fr_ff   <= nxt_fr;
      dom_ff  <= nxt_dom;
      pid_ff  <= nxt_pid;
      len_ff  <= nxt_len;
      idx_ff  <= nxt_idx;
      sum_ff  <= nxt_sum;
      diag_ff <= nxt_diag;
      hv_ff   <= nxt_hv;
      rxv_ff  <= nxt_rxv;
      rxd_ff  <= nxt_rxd;
      hit_ff  <= nxt_hit;
      ok_ff   <= nxt_ok;
    end
  end

  // response transmitter with read-back check
  logic [9:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_cnt_ff, nxt_tx_cnt;
  logic [3:0] tx_bits_ff, nxt_tx_bits;
  logic       tx_busy_ff, nxt_tx_busy;
  logic       txd_ff, nxt_txd;
  logic       bit_ev;

  always_comb begin
    nxt_tx_sh   = tx_sh_ff;
    nxt_tx_cnt  = tx_cnt_ff;
    nxt_tx_bits = tx_bits_ff;
    nxt_tx_busy = tx_busy_ff;
    bit_ev      = 1'b0;
    if (!tx_busy_ff) begin
      if (TX_REQ && addr_valid) begin
        nxt_tx_sh   = {1'b1, TX_DATA, 1'b0};
        nxt_tx_cnt  = 4'h0;
        nxt_tx_bits = 4'h0;
        nxt_tx_busy = 1'b1;
      end
    end else if (tick_ff) begin
      nxt_tx_cnt = tx_cnt_ff + 4'h1;
      if (tx_cnt_ff == TX_SAMPLE && LIN_RXD != tx_sh_ff[0]) begin
        bit_ev = 1'b1;
      end
      if (tx_cnt_ff == 4'(`LIN_BIT_LAST)) begin
        nxt_tx_sh   = {1'b1, tx_sh_ff[9:1]};
        nxt_tx_bits = tx_bits_ff + 4'h1;
        nxt_tx_busy = (tx_bits_ff != 4'd9);
      end
    end
    nxt_txd = nxt_tx_busy ? nxt_tx_sh[0] : 1'b1;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tx_sh_ff   <= 10'h3FF;
      tx_cnt_ff  <= 4'h0;
      tx_bits_ff <= 4'h0;
      tx_busy_ff <= 1'b0;
      txd_ff     <= 1'b1;
    end else begin
      tx_sh_ff   <= nxt_tx_sh;
      tx_cnt_ff  <= nxt_tx_cnt;
      tx_bits_ff <= nxt_tx_bits;
      tx_busy_ff <= nxt_tx_busy;
      txd_ff     <= nxt_txd;
    end
  end

  // sticky error flags, a new event beats a same-cycle clear
  logic [4:0] flags_ff, nxt_flags;
  logic       clr_resp, clr_hdr;

  always_comb begin
    clr_resp  = READ_FULL_STATUS_CMD || READ_POSITION_CMD;
    clr_hdr   = READ_FULL_STATUS_CMD;
    nxt_flags = flags_ff;
    if (clr_resp) begin
      nxt_flags[`LIN_ERR_BIT]  = 1'b0;
      nxt_flags[`LIN_ERR_DATA] = 1'b0;
      nxt_flags[`LIN_ERR_RESP] = 1'b0;
    end
    if (clr_hdr) begin
      nxt_flags[`LIN_ERR_HEADER]  = 1'b0;
      nxt_flags[`LIN_ERR_TIMEOUT] = 1'b0;
    end
    nxt_flags[`LIN_ERR_BIT]     = nxt_flags[`LIN_ERR_BIT] | bit_ev;
    nxt_flags[`LIN_ERR_HEADER]  = nxt_flags[`LIN_ERR_HEADER] | hdr_ev;
    nxt_flags[`LIN_ERR_DATA]    = nxt_flags[`LIN_ERR_DATA] | data_ev;
    nxt_flags[`LIN_ERR_TIMEOUT] = nxt_flags[`LIN_ERR_TIMEOUT] | to_ev;
    nxt_flags[`LIN_ERR_RESP]    = nxt_flags[`LIN_ERR_RESP] | data_ev | bit_ev;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      flags_ff <= 5'(`LIN_ERR_RESET);
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // outputs straight from flops
  assign LIN_TXD          = txd_ff;
  assign TX_BUSY          = tx_busy_ff;
  assign LINK_ERROR_FLAGS = {3'b000, flags_ff};
  assign NODE_ADDR        = node_addr;
  assign NODE_ADDR_VALID  = addr_valid;
  assign HEADER_VALID     = hv_ff;
  assign PID              = pid_ff;
  assign RX_VALID         = rxv_ff;
  assign RX_DATA          = rxd_ff;
  assign NAD_HIT          = hit_ff;
  assign FRAME_OK         = ok_ff;

  // checks
  sequence s_full_read;
    READ_FULL_STATUS_CMD && !bit_ev && !hdr_ev && !data_ev && !to_ev;
  endsequence

  sequence s_pos_read;
    READ_POSITION_CMD && !READ_FULL_STATUS_CMD && !bit_ev && !data_ev;
  endsequence

  a_tick_spacing: assert property (@(posedge REF_CLK) disable iff (RST)
    tick_ff |-> ##1 !tick_ff)
    else $error("sampling tick not a single pulse");

  a_resp_follows: assert property (@(posedge REF_CLK) disable iff (RST)
    ($rose(flags_ff[`LIN_ERR_DATA]) || $rose(flags_ff[`LIN_ERR_BIT])) |-> flags_ff[`LIN_ERR_RESP])
    else $error("response flag missing");

  a_full_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    s_full_read |=> flags_ff == 5'h00)
    else $error("full status read left flags set");

  a_pos_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    s_pos_read |=> !flags_ff[`LIN_ERR_BIT] && !flags_ff[`LIN_ERR_DATA] && !flags_ff[`LIN_ERR_RESP]
      && flags_ff[`LIN_ERR_HEADER] == ($past(flags_ff[`LIN_ERR_HEADER]) | $past(hdr_ev))
      && flags_ff[`LIN_ERR_TIMEOUT] == ($past(flags_ff[`LIN_ERR_TIMEOUT]) | $past(to_ev)))
    else $error("position read cleared wrong flags");

  a_flags_sticky: assert property (@(posedge REF_CLK) disable iff (RST)
    (!READ_FULL_STATUS_CMD && !READ_POSITION_CMD) |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("flag dropped without a clearing read");

  a_bit_mismatch: assert property (@(posedge REF_CLK) disable iff (RST)
    (tx_busy_ff && tick_ff && tx_cnt_ff == TX_SAMPLE && LIN_RXD != tx_sh_ff[0]) |=> flags_ff[`LIN_ERR_BIT])
    else $error("read-back mismatch not flagged");

  a_pid_parity: assert property (@(posedge REF_CLK) disable iff (RST)
    (fr_ff == lin_pkg::FR_PID && rx_valid && !par_ok && !break_ev) |=> flags_ff[`LIN_ERR_HEADER] && !hv_ff)
    else $error("bad identifier parity not flagged");

  a_timeout_flag: assert property (@(posedge REF_CLK) disable iff (RST)
    to_ev |=> flags_ff[`LIN_ERR_TIMEOUT])
    else $error("long dominant not flagged");

  a_link_off: assert property (@(posedge REF_CLK) disable iff (RST)
    !addr_valid |=> !hv_ff && !tx_busy_ff)
    else $error("link active before address latched");

  a_reserved_zero: assert property (@(posedge REF_CLK) disable iff (RST)
    LINK_ERROR_FLAGS[7:5] == 3'b000)
    else $error("unused flag bits not zero");

  a_nad_bcast: assert property (@(posedge REF_CLK) disable iff (RST)
    (fr_ff == lin_pkg::FR_DATA && diag_ff && idx_ff == 4'h0 && rx_valid && rx_stop_ok && !break_ev)
      |=> hit_ff == ($past(rx_byte) == `LIN_NAD_BCAST
                  || ($past(rx_byte) == {1'b0, node_addr} && node_addr >= `LIN_NAD_MIN
                      && node_addr <= `LIN_NAD_MAX)))
    else $error("address match wrong");

endmodule // lin_slave_protocol_handler

`default_nettype wire

/* File: verification/lin_master_model.sv */
`timescale 1ns/10ps
`default_nettype none

// bus master model: open-drain line, wired-and with the slave driver
module lin_master_model #(
  parameter int BIT_CYC = 64
) (
  // clock
  input  wire logic clk,
  // bus
  input  wire logic txd,
  output var  logic rxd
);
  logic drv = 1'b1;

  // pull-up line: dominant when either party drives low
  assign rxd = drv & txd;

  // hold one level for n bit times
  task automatic hold(input logic lvl, input int n);
    drv = lvl;
    repeat (n * BIT_CYC) @(negedge clk);
  endtask

  // start bit, eight bits lsb first, stop bit
  task automatic send_byte(input logic [7:0] b, input logic stop);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], 1);
    end
    hold(stop, 1);
  endtask

  // break, delimiter, sync and identifier
  task automatic header(input logic [7:0] pid);
    hold(1'b0, 13);
    hold(1'b1, 1);
    send_byte(8'h55, 1'b1);
    send_byte(pid, 1'b1);
  endtask
endmodule // lin_master_model

`default_nettype wire

/* File: verification/test_lin_slave_protocol_handler.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lin_regs.svh"

module test_lin_slave_protocol_handler;
  logic        ref_clk = 1'b0;
  logic        rst, rxd, txd, mode, tx_req, tx_busy, rd_full, rd_pos, valid, hit, rx_valid, ok, hv, top_ok;
  logic [7:0]  tx_data, flags, rx_data, pid;
  logic [3:0]  otp;
  logic [2:0]  pins;
  logic [6:0]  addr, exp_addr;
  logic [31:0] seed;
  logic [7:0]  exp_q[$];
  logic [7:0]  nads[4] = '{8'h00, 8'h7E, 8'h7F, 8'hFF};
  int          bad_count, checked, oks;

  lin_master_model #(.BIT_CYC(64)) m_u (.clk(ref_clk), .txd(txd), .rxd(rxd));

  lin_slave_protocol_handler #(.OVS_DIV(4)) dut_u (
    .REF_CLK(ref_clk), .RST(rst), .LIN_RXD(rxd), .LIN_TXD(txd), .OTP_ADDR(otp),
    .ADDRESS_MODE_SELECT(mode), .HARDWIRED_ADDRESS_PINS(pins), .HARDWIRED_ADDRESS_TOP_PIN_RESOLVED(top_ok),
    .TX_REQ(tx_req), .TX_DATA(tx_data), .TX_BUSY(tx_busy), .READ_FULL_STATUS_CMD(rd_full),
    .READ_POSITION_CMD(rd_pos), .LINK_ERROR_FLAGS(flags), .NODE_ADDR(addr), .NODE_ADDR_VALID(valid),
    .HEADER_VALID(hv), .PID(pid), .RX_VALID(rx_valid), .RX_DATA(rx_data), .NAD_HIT(hit), .FRAME_OK(ok));

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] pid_of(input logic [5:0] id);
    return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction

  function automatic logic hit_of(input logic [7:0] nad);
    return nad == `LIN_NAD_BCAST || (nad[7] == 1'b0 && nad[6:0] == exp_addr && exp_addr >= 1 && exp_addr <= 125);
  endfunction

  task automatic wrap_up;
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // diagnostic frame: nad plus random bytes when the address is valid, classic checksum
  task automatic frame(input logic [7:0] nad, input logic [7:0] flip);
    int         sum;
    logic [7:0] b[8];
    logic       live;
    sum = 0;
    live = valid;
    m_u.header(pid_of(6'h3C));
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      b[i] = (i == 0) ? nad : seed[7:0];
      if (live) exp_q.push_back(b[i]);
      sum = sum + b[i];
      if (sum > 255) sum = sum - 255;
    end
    if (live) foreach (b[i]) m_u.send_byte(b[i], 1'b1);
    m_u.send_byte(~sum[7:0] ^ flip, 1'b1);
    m_u.hold(1'b1, 2);
  endtask

  // one read command pulse
  task automatic rd(input logic full);
    @(negedge ref_clk);
    rd_full = full;
    rd_pos = ~full;
    @(negedge ref_clk);
    rd_full = 1'b0;
    rd_pos = 1'b0;
    @(negedge ref_clk);
  endtask

  // one response byte, bounded wait for completion
  task automatic send(input logic [7:0] d);
    @(negedge ref_clk);
    tx_data = d;
    tx_req = 1'b1;
    @(negedge ref_clk);
    tx_req = 1'b0;
    for (int n = 0; n < 2000 && tx_busy !== 1'b0; n++) @(negedge ref_clk);
    if (tx_busy !== 1'b0) begin
      bad_count++;
      wrap_up();
    end
    m_u.hold(1'b1, 1);
  endtask

  // reference queue of data bytes the slave must report
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1 && exp_q.size() > 0) chk(rx_data, exp_q.pop_front());
    if (hv === 1'b1) chk(pid, pid_of(6'h3C));
    if (ok === 1'b1) begin
      oks++;
      chk(8'(exp_q.size()), 8'h00);
    end
  end

  // cut a hang short
  initial begin
    repeat (95000) @(posedge ref_clk);
    bad_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    seed = lfsr(32'h0000_e3df);
    {mode, pins, otp} = seed[7:0];
    {rst, tx_req, tx_data, rd_full, rd_pos, top_ok} = {1'b1, 12'h000};
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    chk(flags, `LIN_ERR_RESET);
    chk({7'h00, valid}, 8'h00);
    exp_addr = mode ? {pins, otp[3:1], ~otp[0]} : {otp[3:1], ~otp[0], pins};
    frame(8'h7F, 8'h00);
    chk({7'h00, valid}, 8'h00);
    top_ok = 1'b1;
    frame(8'h7F, 8'h00);
    chk({valid, addr}, {1'b1, exp_addr});
    pins = ~pins;
    frame({1'b0, exp_addr}, 8'h00);
    chk({hit, addr}, {hit_of({1'b0, exp_addr}), exp_addr});
    for (int i = 0; i < 4; i++) begin
      frame(nads[i], 8'h00);
      chk({7'h00, hit}, {7'h00, hit_of(nads[i])});
    end
    chk(8'(oks), 8'h05);
    frame(8'h7F, 8'h01);
    chk(flags, 8'h14);
    rd(1'b0);
    chk(flags, 8'h00);
    m_u.header(pid_of(6'h3C) ^ 8'h80);
    m_u.hold(1'b1, 2);
    m_u.hold(1'b0, 50);
    m_u.hold(1'b1, 2);
    chk(flags, 8'h0A);
    rd(1'b0);
    chk(flags, 8'h0A);
    rd(1'b1);
    chk(flags, 8'h00);
    send(8'hA5);
    chk(flags, 8'h00);
    m_u.drv = 1'b0;
    send(8'hA5);
    chk(flags, 8'h11);
    wrap_up();
  end
endmodule // test_lin_slave_protocol_handler

`default_nettype wire
